// ==== pkg/metering_pkg.sv ====
// constants shared by the metering front end and its delay lines
package metering_pkg;

  // ************************************************************
  // data widths
  // ************************************************************
  localparam int unsigned ADC_RAW_W  = 21;  // converter word before sign duplication
  localparam int unsigned SAMPLE_W   = 22;  // delivered word, bit21 and bit20 carry sign
  localparam int unsigned MAG_W      = 8;   // delay magnitude width
  localparam int unsigned DEPTH      = 256; // delay chain length in samples
  localparam int unsigned REG_W      = 8;   // register width
  localparam int unsigned ADDR_W     = 16;  // bus address width

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [13:0] IDX_ADC_CHANNEL_ENABLE_CTRL = 14'h2864;
  localparam logic [13:0] IDX_METERING_CLOCK_CTRL     = 14'h2867;
  localparam logic [13:0] IDX_CHANNEL_PATH_CTRL       = 14'h2878;
  localparam logic [13:0] IDX_PHASE_TRIM_LOW_CH1      = 14'h287b;
  localparam logic [13:0] IDX_PHASE_TRIM_LOW_CH2      = 14'h287c;
  localparam logic [13:0] IDX_PHASE_TRIM_HIGH_BITS    = 14'h287f;
  localparam logic [13:0] IDX_FRONT_END_STATUS        = 14'h2880;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned VOLTAGE_CONV_ENABLE_BIT   = 2;
  localparam int unsigned CURRENT_B_CONV_ENABLE_BIT = 1;
  localparam int unsigned CURRENT_A_CONV_ENABLE_BIT = 0;
  localparam int unsigned CURRENT_SWAP_SELECT_BIT   = 5;
  localparam int unsigned PHASE_COMP_ENABLE_BIT     = 6;
  localparam int unsigned METERING_CLOCK_SELECT_LSB = 2;
  localparam int unsigned TRIM_SIGN_BIT             = 7;
  localparam int unsigned CH1_TRIM_UPPER_LSB        = 0;
  localparam int unsigned CH2_TRIM_UPPER_LSB        = 2;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_ADC_CHANNEL_ENABLE_CTRL = 8'h00;
  localparam logic [7:0] RST_METERING_CLOCK_CTRL     = 8'h00;
  localparam logic [7:0] RST_CHANNEL_PATH_CTRL       = 8'h00;
  localparam logic [7:0] RST_PHASE_TRIM              = 8'h00;

  // ************************************************************
  // sample rate generation
  // ************************************************************
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned BASE_RATE_HZ = 819_200;
  localparam int unsigned ACC_W        = 27;

  // ************************************************************
  // bus responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== pkg/trim_delay_if.sv ====
// carrier between the front end and one phase delay line
`timescale 1ns/1ps
interface trim_delay_if;
  logic                               tick;
  logic                               comp_enable;
  logic                               trim_sign;
  logic [metering_pkg::MAG_W-1:0]     trim_mag;
  logic [metering_pkg::SAMPLE_W-1:0]  cur_in;
  logic [metering_pkg::SAMPLE_W-1:0]  volt_in;
  logic [metering_pkg::SAMPLE_W-1:0]  cur_out;
  logic [metering_pkg::SAMPLE_W-1:0]  volt_out;

  modport ctrl (output tick, comp_enable, trim_sign, trim_mag, cur_in, volt_in,
                input cur_out, volt_out);
  modport line (input tick, comp_enable, trim_sign, trim_mag, cur_in, volt_in,
                output cur_out, volt_out);
endinterface

// ==== core/phase_delay_line.sv ====
// fixed-length delay chain that delays either the current or the voltage stream
`timescale 1ns/1ps
module phase_delay_line (
  input  wire logic   clk,
  input  wire logic   arst_n,
  trim_delay_if.line  dl
);

  // ************************************************************
  // declarations
  // ************************************************************
  localparam int unsigned DW = metering_pkg::SAMPLE_W;
  localparam int unsigned MW = metering_pkg::MAG_W;

  logic [DW-1:0] mem_q [metering_pkg::DEPTH];
  logic [MW-1:0] wr_q;
  logic [MW-1:0] wr_d;
  logic [MW-1:0] eff_mag;
  logic [MW-1:0] rd_idx;
  logic [DW-1:0] sel_in;
  logic [DW-1:0] tapped;
  logic [DW-1:0] cur_q;
  logic [DW-1:0] cur_d;
  logic [DW-1:0] volt_q;
  logic [DW-1:0] volt_d;

  // ************************************************************
  // stream selection and tap
  // ************************************************************
  // disabled compensation forces a zero delay whatever the trim holds
  always_comb begin
    eff_mag = dl.comp_enable ? dl.trim_mag : '0;         // [RQ6] [RQ16]
    sel_in  = dl.trim_sign ? dl.volt_in : dl.cur_in;     // [RQ10]
    rd_idx  = wr_q - eff_mag;
    tapped  = (eff_mag == '0) ? sel_in : mem_q[rd_idx];  // [RQ15]
    wr_d    = dl.tick ? wr_q + 1'b1 : wr_q;
    cur_d   = cur_q;
    volt_d  = volt_q;
    if (dl.tick) begin
      cur_d  = dl.trim_sign ? dl.cur_in : tapped;        // [RQ5] [RQ10]
      volt_d = dl.trim_sign ? tapped : dl.volt_in;       // [RQ5] [RQ10]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q   <= '0;
      cur_q  <= '0;
      volt_q <= '0;
    end else begin
      wr_q   <= wr_d;
      cur_q  <= cur_d;
      volt_q <= volt_d;
    end
  end

  // ************************************************************
  // delay storage, one entry per sample slot
  // ************************************************************
  for (genvar i = 0; i < metering_pkg::DEPTH; i++) begin : g_slot
    logic [DW-1:0] ent_d;
    assign ent_d = (dl.tick && wr_q == MW'(i)) ? sel_in : mem_q[i];
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_q[i] <= '0;
      end else begin
        mem_q[i] <= ent_d;
      end
    end
  end

  assign dl.cur_out  = cur_q;
  assign dl.volt_out = volt_q;

endmodule

// ==== core/metering_front_end.sv ====
// metering front end: channel enables, current swap and phase compensation
//
// What this block does
// RQ1: each converter disabled after reset, own enable bit
// RQ2: results are 22 bits, bit21 and bit20 sign
// RQ3: bit5 swap routes current A/B to paths
// RQ4: all three streams pass phase compensation next
// RQ5: delay one selected stream through fixed chain
// RQ6: compensation off after reset, bit6 enables it
// RQ7: path 1 and path 2 corrected independently
// RQ8: trims combine low register with shared upper bits
// RQ9: bit7 sign, bit6 ignored, eight-bit magnitude
// RQ10: sign 0 delays current, 1 delays voltage
// RQ11: clock select picks 819200, 1638400, 3276800 Hz
// RQ12: finest step 0.0055 degrees, range 1.4 degrees
// RQ13: software computes signed count from metering error
// RQ14: clock select scales 819.2 kHz base by 1,2,4
// RQ15: delay equals magnitude in samples, other undelayed
// RQ16: inactive compensation adds no delay to either
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module metering_front_end (
  input  wire logic                               CLK_IN,
  input  wire logic                               ARST_N_IN,
  // converter words, same clock domain
  input  wire logic [metering_pkg::ADC_RAW_W-1:0] VOLTAGE_ADC_IN,
  input  wire logic [metering_pkg::ADC_RAW_W-1:0] CURRENT_INPUT_A_IN,
  input  wire logic [metering_pkg::ADC_RAW_W-1:0] CURRENT_INPUT_B_IN,
  // compensated streams
  output logic                                    SAMPLE_TICK_OUT,
  output logic      [metering_pkg::SAMPLE_W-1:0]  CURRENT_PATH_1_OUT,
  output logic      [metering_pkg::SAMPLE_W-1:0]  VOLTAGE_PATH_1_OUT,
  output logic      [metering_pkg::SAMPLE_W-1:0]  CURRENT_PATH_2_OUT,
  output logic      [metering_pkg::SAMPLE_W-1:0]  VOLTAGE_PATH_2_OUT,
  // axi4-lite slave
  input  wire logic [metering_pkg::ADDR_W-1:0]    AWADDR_IN,
  input  wire logic                               AWVALID_IN,
  output logic                                    AWREADY_OUT,
  input  wire logic [31:0]                        WDATA_IN,
  input  wire logic [3:0]                         WSTRB_IN,
  input  wire logic                               WVALID_IN,
  output logic                                    WREADY_OUT,
  output logic      [1:0]                         BRESP_OUT,
  output logic                                    BVALID_OUT,
  input  wire logic                               BREADY_IN,
  input  wire logic [metering_pkg::ADDR_W-1:0]    ARADDR_IN,
  input  wire logic                               ARVALID_IN,
  output logic                                    ARREADY_OUT,
  output logic      [31:0]                        RDATA_OUT,
  output logic      [1:0]                         RRESP_OUT,
  output logic                                    RVALID_OUT,
  input  wire logic                               RREADY_IN
);

  // ************************************************************
  // declarations
  // ************************************************************
  localparam int unsigned DW = metering_pkg::SAMPLE_W;
  localparam int unsigned AW = metering_pkg::ACC_W;
  localparam logic [AW-1:0] CLK_HZ_C  = AW'(metering_pkg::CLK_HZ);
  localparam logic [AW-1:0] BASE_HZ_C = AW'(metering_pkg::BASE_RATE_HZ);

  logic [7:0]    adc_channel_enable_ctrl_q;
  logic [7:0]    adc_channel_enable_ctrl_d;
  logic [7:0]    metering_clock_ctrl_q;
  logic [7:0]    metering_clock_ctrl_d;
  logic [7:0]    channel_path_ctrl_q;
  logic [7:0]    channel_path_ctrl_d;
  logic [7:0]    phase_trim_low_ch1_q;
  logic [7:0]    phase_trim_low_ch1_d;
  logic [7:0]    phase_trim_low_ch2_q;
  logic [7:0]    phase_trim_low_ch2_d;
  logic [7:0]    phase_trim_high_bits_q;
  logic [7:0]    phase_trim_high_bits_d;
  logic          bvalid_q;
  logic          bvalid_d;
  logic [1:0]    bresp_q;
  logic [1:0]    bresp_d;
  logic          rvalid_q;
  logic          rvalid_d;
  logic [1:0]    rresp_q;
  logic [1:0]    rresp_d;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;
  logic          wr_take;
  logic          rd_take;
  logic [13:0]   wr_idx;
  logic [13:0]   rd_idx;

  logic [AW-1:0] acc_q;
  logic [AW-1:0] acc_d;
  logic [AW-1:0] rate_inc;
  logic [AW-1:0] acc_sum;
  logic          tick;

  logic          voltage_conv_enable;
  logic          current_b_conv_enable;
  logic          current_a_conv_enable;
  logic          current_swap_select;
  logic          phase_comp_enable;
  logic [1:0]    metering_clock_select;
  logic [1:0]    ch1_trim_upper_bits;
  logic [1:0]    ch2_trim_upper_bits;
  logic [DW-1:0] volt_word;
  logic [DW-1:0] cur_a_word;
  logic [DW-1:0] cur_b_word;
  logic [DW-1:0] current_path_1;
  logic [DW-1:0] current_path_2;

  trim_delay_if path1_if ();
  trim_delay_if path2_if ();

  // ************************************************************
  // register fields
  // ************************************************************
  assign voltage_conv_enable   =
    adc_channel_enable_ctrl_q[metering_pkg::VOLTAGE_CONV_ENABLE_BIT];   // [RQ1]
  assign current_b_conv_enable =
    adc_channel_enable_ctrl_q[metering_pkg::CURRENT_B_CONV_ENABLE_BIT]; // [RQ1]
  assign current_a_conv_enable =
    adc_channel_enable_ctrl_q[metering_pkg::CURRENT_A_CONV_ENABLE_BIT]; // [RQ1]
  assign current_swap_select   =
    channel_path_ctrl_q[metering_pkg::CURRENT_SWAP_SELECT_BIT];
  assign phase_comp_enable     =
    channel_path_ctrl_q[metering_pkg::PHASE_COMP_ENABLE_BIT];
  assign metering_clock_select =
    metering_clock_ctrl_q[metering_pkg::METERING_CLOCK_SELECT_LSB +: 2];
  assign ch1_trim_upper_bits   =
    phase_trim_high_bits_q[metering_pkg::CH1_TRIM_UPPER_LSB +: 2];     // [RQ8]
  assign ch2_trim_upper_bits   =
    phase_trim_high_bits_q[metering_pkg::CH2_TRIM_UPPER_LSB +: 2];     // [RQ8]

  // ************************************************************
  // converter words and current routing
  // ************************************************************
  // a disabled channel delivers zeros; sign copied into bit21 and bit20
  always_comb begin
    volt_word  = voltage_conv_enable ?
                 {VOLTAGE_ADC_IN[20], VOLTAGE_ADC_IN} : '0;           // [RQ1] [RQ2]
    cur_a_word = current_a_conv_enable ?
                 {CURRENT_INPUT_A_IN[20], CURRENT_INPUT_A_IN} : '0;   // [RQ1] [RQ2]
    cur_b_word = current_b_conv_enable ?
                 {CURRENT_INPUT_B_IN[20], CURRENT_INPUT_B_IN} : '0;   // [RQ1] [RQ2]
    current_path_1 = current_swap_select ? cur_b_word : cur_a_word;  // [RQ3]
    current_path_2 = current_swap_select ? cur_a_word : cur_b_word;  // [RQ3]
  end

  // ************************************************************
  // compensation sample rate
  // ************************************************************
  // fractional divider gives the exact average rate from the 40 MHz clock;
  // code 11 is treated as the base rate
  always_comb begin
    case (metering_clock_select)
      2'h1:    rate_inc = BASE_HZ_C << 1;  // [RQ11] [RQ14]
      2'h2:    rate_inc = BASE_HZ_C << 2;  // [RQ11] [RQ12] [RQ14]
      default: rate_inc = BASE_HZ_C;       // [RQ11] [RQ14]
    endcase
    acc_sum = acc_q + rate_inc;
    tick    = (acc_sum >= CLK_HZ_C);
    acc_d   = tick ? acc_sum - CLK_HZ_C : acc_sum;
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ************************************************************
  // phase compensation, one delay line per current path
  // ************************************************************
  // each path carries its own trim and its own copy of the voltage stream
  always_comb begin
    path1_if.tick        = tick;
    path1_if.comp_enable = phase_comp_enable;                             // [RQ6]
    path1_if.trim_sign   = phase_trim_low_ch1_q[metering_pkg::TRIM_SIGN_BIT]; // [RQ9]
    path1_if.trim_mag    = {ch1_trim_upper_bits, phase_trim_low_ch1_q[5:0]};  // [RQ8] [RQ9]
    path1_if.cur_in      = current_path_1;                                // [RQ4]
    path1_if.volt_in     = volt_word;                                     // [RQ4]
    path2_if.tick        = tick;
    path2_if.comp_enable = phase_comp_enable;                             // [RQ6]
    path2_if.trim_sign   = phase_trim_low_ch2_q[metering_pkg::TRIM_SIGN_BIT]; // [RQ9]
    path2_if.trim_mag    = {ch2_trim_upper_bits, phase_trim_low_ch2_q[5:0]};  // [RQ8] [RQ9]
    path2_if.cur_in      = current_path_2;                                // [RQ4]
    path2_if.volt_in     = volt_word;                                     // [RQ4]
  end

  // independent correction of path 1 against voltage
  phase_delay_line u_path1 (
    .clk    (CLK_IN),
    .arst_n (ARST_N_IN),
    .dl     (path1_if.line)
  );  // [RQ7]

  // independent correction of path 2 against voltage
  phase_delay_line u_path2 (
    .clk    (CLK_IN),
    .arst_n (ARST_N_IN),
    .dl     (path2_if.line)
  );  // [RQ7]

  assign CURRENT_PATH_1_OUT = path1_if.cur_out;
  assign VOLTAGE_PATH_1_OUT = path1_if.volt_out;
  assign CURRENT_PATH_2_OUT = path2_if.cur_out;
  assign VOLTAGE_PATH_2_OUT = path2_if.volt_out;

  // outputs update one cycle after the sample tick
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SAMPLE_TICK_OUT <= 1'b0;
    end else begin
      SAMPLE_TICK_OUT <= tick;
    end
  end

  // ************************************************************
  // axi4-lite register access
  // ************************************************************
  // write address and data are taken together when no response is pending
  assign AWREADY_OUT = AWVALID_IN && WVALID_IN && !bvalid_q;
  assign WREADY_OUT  = AWREADY_OUT;
  assign ARREADY_OUT = !rvalid_q;
  assign wr_take     = AWREADY_OUT;
  assign rd_take     = ARVALID_IN && ARREADY_OUT;
  assign wr_idx      = AWADDR_IN[15:2];
  assign rd_idx      = ARADDR_IN[15:2];
  assign BVALID_OUT  = bvalid_q;
  assign BRESP_OUT   = bresp_q;
  assign RVALID_OUT  = rvalid_q;
  assign RRESP_OUT   = rresp_q;
  assign RDATA_OUT   = rdata_q;

  // next register and response values
  always_comb begin
    adc_channel_enable_ctrl_d = adc_channel_enable_ctrl_q;
    metering_clock_ctrl_d     = metering_clock_ctrl_q;
    channel_path_ctrl_d       = channel_path_ctrl_q;
    phase_trim_low_ch1_d      = phase_trim_low_ch1_q;
    phase_trim_low_ch2_d      = phase_trim_low_ch2_q;
    phase_trim_high_bits_d    = phase_trim_high_bits_q;
    bvalid_d = bvalid_q && !BREADY_IN;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q && !RREADY_IN;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (wr_take) begin
      bvalid_d = 1'b1;
      bresp_d  = metering_pkg::RESP_OKAY;
      if (wr_idx == metering_pkg::IDX_ADC_CHANNEL_ENABLE_CTRL) begin
        if (WSTRB_IN[0]) adc_channel_enable_ctrl_d = WDATA_IN[7:0];
      end else if (wr_idx == metering_pkg::IDX_METERING_CLOCK_CTRL) begin
        if (WSTRB_IN[0]) metering_clock_ctrl_d = WDATA_IN[7:0];
      end else if (wr_idx == metering_pkg::IDX_CHANNEL_PATH_CTRL) begin
        if (WSTRB_IN[0]) channel_path_ctrl_d = WDATA_IN[7:0];
      end else if (wr_idx == metering_pkg::IDX_PHASE_TRIM_LOW_CH1) begin
        if (WSTRB_IN[0]) phase_trim_low_ch1_d = WDATA_IN[7:0];
      end else if (wr_idx == metering_pkg::IDX_PHASE_TRIM_LOW_CH2) begin
        if (WSTRB_IN[0]) phase_trim_low_ch2_d = WDATA_IN[7:0];
      end else if (wr_idx == metering_pkg::IDX_PHASE_TRIM_HIGH_BITS) begin
        if (WSTRB_IN[0]) phase_trim_high_bits_d = WDATA_IN[7:0];
      end else if (wr_idx == metering_pkg::IDX_FRONT_END_STATUS) begin
        bresp_d = metering_pkg::RESP_OKAY;  // read-only, write ignored
      end else begin
        bresp_d = metering_pkg::RESP_SLVERR;
      end
    end
    if (rd_take) begin
      rvalid_d = 1'b1;
      rresp_d  = metering_pkg::RESP_OKAY;
      rdata_d  = 32'h0;
      if (rd_idx == metering_pkg::IDX_ADC_CHANNEL_ENABLE_CTRL) begin
        rdata_d[7:0] = adc_channel_enable_ctrl_q;
      end else if (rd_idx == metering_pkg::IDX_METERING_CLOCK_CTRL) begin
        rdata_d[7:0] = metering_clock_ctrl_q;
      end else if (rd_idx == metering_pkg::IDX_CHANNEL_PATH_CTRL) begin
        rdata_d[7:0] = channel_path_ctrl_q;
      end else if (rd_idx == metering_pkg::IDX_PHASE_TRIM_LOW_CH1) begin
        rdata_d[7:0] = phase_trim_low_ch1_q;
      end else if (rd_idx == metering_pkg::IDX_PHASE_TRIM_LOW_CH2) begin
        rdata_d[7:0] = phase_trim_low_ch2_q;
      end else if (rd_idx == metering_pkg::IDX_PHASE_TRIM_HIGH_BITS) begin
        rdata_d[7:0] = phase_trim_high_bits_q;
      end else if (rd_idx == metering_pkg::IDX_FRONT_END_STATUS) begin
        // live view: comp active, swap, rate code, converter enables
        rdata_d[7:0] = {phase_comp_enable, current_swap_select, metering_clock_select,
                        1'b0, voltage_conv_enable, current_b_conv_enable,
                        current_a_conv_enable};
      end else begin
        rresp_d = metering_pkg::RESP_SLVERR;
      end
    end
  end

  // register storage, cleared so that converters and compensation start off
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      adc_channel_enable_ctrl_q <= metering_pkg::RST_ADC_CHANNEL_ENABLE_CTRL; // [RQ1]
      metering_clock_ctrl_q     <= metering_pkg::RST_METERING_CLOCK_CTRL;
      channel_path_ctrl_q       <= metering_pkg::RST_CHANNEL_PATH_CTRL;  // [RQ3] [RQ6]
      phase_trim_low_ch1_q      <= metering_pkg::RST_PHASE_TRIM;
      phase_trim_low_ch2_q      <= metering_pkg::RST_PHASE_TRIM;
      phase_trim_high_bits_q    <= metering_pkg::RST_PHASE_TRIM;
      bvalid_q                  <= 1'b0;
      bresp_q                   <= metering_pkg::RESP_OKAY;
      rvalid_q                  <= 1'b0;
      rresp_q                   <= metering_pkg::RESP_OKAY;
      rdata_q                   <= 32'h0;
    end else begin
      adc_channel_enable_ctrl_q <= adc_channel_enable_ctrl_d;
      metering_clock_ctrl_q     <= metering_clock_ctrl_d;
      channel_path_ctrl_q       <= channel_path_ctrl_d;
      phase_trim_low_ch1_q      <= phase_trim_low_ch1_d;
      phase_trim_low_ch2_q      <= phase_trim_low_ch2_d;
      phase_trim_high_bits_q    <= phase_trim_high_bits_d;
      bvalid_q                  <= bvalid_d;
      bresp_q                   <= bresp_d;
      rvalid_q                  <= rvalid_d;
      rresp_q                   <= rresp_d;
      rdata_q                   <= rdata_d;
    end
  end

endmodule

// ==== test/adc_source_model.sv ====
// behavioural converter source: random words held between sample ticks
`timescale 1ns/1ps
module adc_source_model (
  input  wire logic        clk,
  input  wire logic        tick,
  output logic      [20:0] volt = 21'h0,
  output logic      [20:0] cur_a = 21'h0,
  output logic      [20:0] cur_b = 21'h0
);
  int          n = -1;
  logic [20:0] hv[int];
  logic [20:0] ha[int];
  logic [20:0] hb[int];
  // new words one edge after a capture, so each word stands across the next tick edge
  always @(posedge clk) begin
    if (tick || n < 0) begin
      hv[n + 1] = 21'($urandom);
      ha[n + 1] = 21'($urandom);
      hb[n + 1] = 21'($urandom);
      volt <= hv[n + 1];
      cur_a <= ha[n + 1];
      cur_b <= hb[n + 1];
      n <= n + 1;
    end
  end
endmodule

// ==== test/metering_front_end_asserts.sv ====
// port-level checks for the metering front end
`timescale 1ns/1ps
module metering_front_end_asserts (
  input wire logic        CLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic        SAMPLE_TICK_OUT,
  input wire logic [21:0] CURRENT_PATH_1_OUT,
  input wire logic        AWVALID_IN,
  input wire logic        WVALID_IN,
  input wire logic        BVALID_OUT,
  input wire logic        BREADY_IN,
  input wire logic [1:0]  BRESP_OUT,
  input wire logic        ARVALID_IN,
  input wire logic        RVALID_OUT,
  input wire logic        RREADY_IN,
  input wire logic [31:0] RDATA_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  write_answer_a: assert property (
    AWVALID_IN && WVALID_IN && !BVALID_OUT |=> BVALID_OUT) else $error("no write answer");
  read_answer_a: assert property (
    ARVALID_IN && !RVALID_OUT |=> RVALID_OUT) else $error("no read answer");
  bresp_hold_a: assert property (
    BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT)) else $error("bresp lost");
  rdata_hold_a: assert property (
    RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT)) else $error("rdata lost");
  read_upper_a: assert property (
    RVALID_OUT |-> RDATA_OUT[31:8] == 24'h0) else $error("upper read bits set");
  sign_copy_a: assert property (
    CURRENT_PATH_1_OUT[21] == CURRENT_PATH_1_OUT[20]) else $error("sign bits differ");
  tick_gap_a: assert property (
    SAMPLE_TICK_OUT |=> !SAMPLE_TICK_OUT [*8]) else $error("ticks too close");
  path_hold_a: assert property (
    $changed(CURRENT_PATH_1_OUT) |-> SAMPLE_TICK_OUT) else $error("path moved off tick");
endmodule

bind metering_front_end metering_front_end_asserts chk_u (.*);

// ==== test/metering_front_end_tb.sv ====
// self-checking bench for the metering front end
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module metering_front_end_tb;
  logic        CLK_IN = 1'b0;
  logic        ARST_N_IN = 1'b0;
  logic [15:0] AWADDR_IN = '0, ARADDR_IN = '0;
  logic [31:0] WDATA_IN = '0, RDATA_OUT;
  logic [3:0]  WSTRB_IN = 4'hf;
  logic        AWVALID_IN = 0, WVALID_IN = 0, BREADY_IN = 0, ARVALID_IN = 0, RREADY_IN = 0;
  logic        SAMPLE_TICK_OUT, AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
  logic [1:0]  BRESP_OUT, RRESP_OUT;
  logic [20:0] volt, cur_a, cur_b;
  logic [21:0] c1, v1, c2, v2;
  logic [33:0] q[$];
  logic [33:0] exp_r;
  logic [1:0]  wq[$], exp_w;
  int          bad_count = 0, n_compared = 0, cyc = 0, k, t0;
  logic [15:0] regs[6] = '{16'ha190, 16'ha19c, 16'ha1e0, 16'ha1ec, 16'ha1f0, 16'ha1fc};
  logic [2:0]  ens[4] = '{3'h1, 3'h2, 3'h4, 3'h7};

  metering_front_end dut_u (.VOLTAGE_ADC_IN(volt), .CURRENT_INPUT_A_IN(cur_a),
    .CURRENT_INPUT_B_IN(cur_b), .CURRENT_PATH_1_OUT(c1), .VOLTAGE_PATH_1_OUT(v1),
    .CURRENT_PATH_2_OUT(c2), .VOLTAGE_PATH_2_OUT(v2), .*);
  adc_source_model adc_u (.clk(CLK_IN), .tick(SAMPLE_TICK_OUT), .volt(volt), .cur_a(cur_a),
    .cur_b(cur_b));

  // clock and cycle count
  always #12.5 CLK_IN = ~CLK_IN;
  always @(posedge CLK_IN) cyc <= cyc + 1;

  // expected word: sign copied into bit21, zero when the converter is off
  function automatic logic [21:0] sx(input logic [20:0] x, input logic on);
    return on ? {x[20], x} : 22'h0;
  endfunction

  // bus write: both channels offered together, bready held until the answer
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    wq.push_back(metering_pkg::RESP_OKAY);
    AWADDR_IN <= a;
    WDATA_IN <= {24'h0, d};
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (AWREADY_OUT) AWVALID_IN <= 1'b0;
      if (WREADY_OUT) WVALID_IN <= 1'b0;
    end while (!BVALID_OUT);
  endtask

  // bus read: expected response and data noted before the request
  task automatic rd(input logic [15:0] a, input logic [33:0] e);
    q.push_back(e);
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (ARREADY_OUT) ARVALID_IN <= 1'b0;
    end while (!RVALID_OUT);
  endtask

  // read monitor takes the oldest note when an answer is accepted
  always @(posedge CLK_IN) begin
    if (RVALID_OUT && RREADY_IN) begin
      exp_r = q.pop_front();
      `CHK("read", exp_r, {RRESP_OUT, RDATA_OUT})
    end
    if (BVALID_OUT && BREADY_IN) begin
      exp_w = wq.pop_front();
      `CHK("write resp", exp_w, BRESP_OUT)
    end
  end

  task automatic tick();
    do @(posedge CLK_IN); while (SAMPLE_TICK_OUT !== 1'b1);
  endtask

  task automatic conclude();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK_IN);
    bad_count++;
    conclude();
  end

  initial begin
    void'($urandom(46130));
    repeat (10) @(posedge CLK_IN);
    ARST_N_IN <= 1'b1;
    @(posedge CLK_IN);
    foreach (regs[i]) rd(regs[i], 34'h0);
    rd({4'h0, 10'($urandom), 2'h0}, {2'h2, 32'h0});
    $display("reset test done");
    for (int s = 0; s < 3; s++) begin
      wr(16'ha19c, 8'(s << 2));
      tick();
      t0 = cyc;
      repeat (16) tick();
      `CHK("tick rate", 1'b1, (((cyc - t0) << s) inside {[720:840]}))
    end
    $display("rate test done");
    for (int s = 0; s < 2; s++) foreach (ens[j]) begin
      wr(16'ha190, {5'h0, ens[j]});
      wr(16'ha1e0, 8'(s << 5));
      repeat (2) tick();
      k = adc_u.n;
      `CHK("path 1", sx(s ? adc_u.hb[k] : adc_u.ha[k], ens[j][s]), c1)
      `CHK("path 2", sx(s ? adc_u.ha[k] : adc_u.hb[k], ens[j][1 - s]), c2)
      `CHK("voltage", sx(adc_u.hv[k], ens[j][2]), v1)
    end
    $display("enable and swap test done");
    wr(16'ha1ec, 8'h43);
    wr(16'ha1f0, 8'hc5);
    wr(16'ha1fc, 8'h01);
    wr(16'ha1e0, 8'h40);
    rd(16'ha1ec, 34'h43);
    rd(16'ha200, 34'ha7);
    repeat (80) tick();
    repeat (3) begin
      tick();
      k = adc_u.n;
      `CHK("late current", sx(adc_u.ha[k - 67], 1'b1), c1)
      `CHK("plain voltage", sx(adc_u.hv[k], 1'b1), v1)
      `CHK("plain current", sx(adc_u.hb[k], 1'b1), c2)
      `CHK("late voltage", sx(adc_u.hv[k - 5], 1'b1), v2)
    end
    wr(16'ha1e0, 8'h00);
    repeat (2) tick();
    k = adc_u.n;
    `CHK("comp off current", sx(adc_u.ha[k], 1'b1), c1)
    `CHK("comp off voltage", sx(adc_u.hv[k], 1'b1), v2)
    $display("compensation test done");
    conclude();
  end
endmodule
